//--- src/iopgm_pkg.sv
// Package with register map, field positions and pin-function encodings.
package iopgm_pkg;

  localparam logic [31:0] CONFIG_ADDR      = 32'he0051008;
  localparam logic [31:0] OVR_STATUS_ADDR  = 32'he0051040;
  localparam int          UPPER_SEL_LSB    = 8;
  localparam int          UPPER_SEL_MSB    = 10;
  localparam int          LOWER_SEL_BIT    = 4;
  localparam int          ACC_UART_BIT     = 1;
  localparam logic [31:0] CONFIG_RESET     = 32'h0000_0000;
  localparam logic [31:0] CONFIG_WMASK     = 32'h0000_0712;
  localparam int          UPPER_FIRST_PIN  = 46;
  localparam int          UPPER_PINS       = 12;
  localparam int          LOWER_FIRST_PIN  = 33;
  localparam int          LOWER_PINS       = 13;
  localparam int          NUM_PINS         = 61;
  localparam int          PIF_LOWER_BASE   = 16;

  typedef enum logic [2:0] {
    UPPER_GPIO          = 3'b000,
    UPPER_GPIO_UART     = 3'b001,
    UPPER_GPIO_SPI      = 3'b010,
    UPPER_GPIO_I2S      = 3'b011,
    UPPER_UART_SPI_I2S  = 3'b100,
    UPPER_PIF_UART_I2S  = 3'b101,
    UPPER_RSVD6         = 3'b110,
    UPPER_RSVD7         = 3'b111
  } iopgm_upper_type;

  // Pin function selection codes driven to the pad multiplexers.
  typedef enum logic [2:0] {
    FN_GPIO    = 3'b000,
    FN_UART    = 3'b001,
    FN_SPI     = 3'b010,
    FN_I2S     = 3'b011,
    FN_PIF     = 3'b100,
    FN_SIMPLE  = 3'b101,
    FN_COMPLEX = 3'b110
  } iopgm_func_type;

  typedef struct packed {
    logic            acc_uart_on_pif;
    logic            lpp_uart_free;
    logic            lower_pif;
    iopgm_upper_type upper_mode;
  } iopgm_route_type;

endpackage : iopgm_pkg

//--- src/iopgm_pin_decode.sv
// Per-pin function decoder for any one pin; pins outside the two switchable groups only see the overrides.
`timescale 1ns/100ps
`default_nettype none
module iopgm_pin_decode #(
  parameter int PIN = 46
) (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire iopgm_pkg::iopgm_route_type route,
  input  wire logic                     basic_override,
  input  wire logic                     advanced_override,
  output iopgm_pkg::iopgm_func_type     func
);

  localparam int UPOS = PIN - iopgm_pkg::UPPER_FIRST_PIN;
  localparam bit IN_UPPER = (PIN >= iopgm_pkg::UPPER_FIRST_PIN) &&
    (PIN < iopgm_pkg::UPPER_FIRST_PIN + iopgm_pkg::UPPER_PINS);
  localparam bit IN_LOWER = (PIN >= iopgm_pkg::LOWER_FIRST_PIN) &&
    (PIN < iopgm_pkg::LOWER_FIRST_PIN + iopgm_pkg::LOWER_PINS);

  // Within the upper group the first four pins carry the UART while it is free, the next
  // four SPI (or parallel data in mode 5) and the last four I2S.
  function automatic iopgm_pkg::iopgm_func_type upper_fn(
    input iopgm_pkg::iopgm_upper_type m, input logic uart_free);
    iopgm_pkg::iopgm_func_type f;
    f = iopgm_pkg::FN_GPIO;
    case (m)
      iopgm_pkg::UPPER_GPIO_UART:
        if (UPOS < 4 && uart_free) f = iopgm_pkg::FN_UART;
      iopgm_pkg::UPPER_GPIO_SPI:
        if (UPOS >= 4 && UPOS < 8) f = iopgm_pkg::FN_SPI;
      iopgm_pkg::UPPER_GPIO_I2S:
        if (UPOS >= 8) f = iopgm_pkg::FN_I2S;
      iopgm_pkg::UPPER_UART_SPI_I2S: begin
        if (UPOS < 4) f = uart_free ? iopgm_pkg::FN_UART
                                    : iopgm_pkg::FN_GPIO;
        else if (UPOS < 8) f = iopgm_pkg::FN_SPI;
        else f = iopgm_pkg::FN_I2S;
      end
      iopgm_pkg::UPPER_PIF_UART_I2S: begin
        if (UPOS < 4) f = uart_free ? iopgm_pkg::FN_UART
                                    : iopgm_pkg::FN_GPIO;
        else if (UPOS < 8) f = iopgm_pkg::FN_PIF;
        else f = iopgm_pkg::FN_I2S;
      end
      default: f = iopgm_pkg::FN_GPIO;
    endcase
    return f;
  endfunction : upper_fn

  wire iopgm_pkg::iopgm_func_type group_fn =
    IN_UPPER ? upper_fn(route.upper_mode, route.lpp_uart_free) :
    (IN_LOWER && route.lower_pif) ? iopgm_pkg::FN_PIF : iopgm_pkg::FN_GPIO;

  // Complex override beats simple override, which beats the group choice.
  wire iopgm_pkg::iopgm_func_type next_func =
    advanced_override ? iopgm_pkg::FN_COMPLEX :
    basic_override    ? iopgm_pkg::FN_SIMPLE  :
    group_fn;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) func <= iopgm_pkg::FN_GPIO;
    else          func <= next_func;
  end

endmodule : iopgm_pin_decode
`default_nettype wire

//--- src/iopgm_top.sv
// Pin-group multiplexer configuration block with its APB register slave.
//
// Design decision made here: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module iopgm_top #(
  parameter int NPINS = iopgm_pkg::NUM_PINS
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [31:0]             paddr,
  input  wire logic [31:0]             pwdata,
  input  wire logic [3:0]              pstrb,
  output logic [31:0]                  prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic [NPINS-1:0]        basic_gpio_override,
  input  wire logic [NPINS-1:0]        advanced_gpio_override,
  output iopgm_pkg::iopgm_func_type    pin_func [NPINS],
  output logic                         acc_uart_on_pif_ctrl,
  output logic                         low_perf_uart_for_acc,
  output logic                         lower_group_pif
);

  // Register word layout: bits 10:8 select the upper group mapping, bit 4
  // the lower group mapping and bit 1 the accessory UART source. All other
  // bits are masked on every write, so they keep their reset value of zero
  // and read back as zero.
  logic [31:0]                io_pin_group_config;
  iopgm_pkg::iopgm_route_type route;

  // Address match, shared by the write path, the read path and the error
  // response so that all three agree on what is mapped.
  function automatic logic reg_hit(
    input logic [31:0] addr,
    input logic [31:0] target
  );
    return addr == target;
  endfunction : reg_hit

  wire sel_config = reg_hit(paddr, iopgm_pkg::CONFIG_ADDR);
  wire sel_status = reg_hit(paddr, iopgm_pkg::OVR_STATUS_ADDR);
  wire mapped     = sel_config || sel_status;

  // Bus phases. The slave never stretches a transfer, so every access
  // phase completes on its first edge.
  wire setup_phase  = psel && !penable;
  wire access_phase = psel && penable;
  wire access       = access_phase && pready;
  wire wr_config    = access && pwrite && sel_config;
  wire rd_setup     = setup_phase && !pwrite;

  // Byte strobes gate whole lanes, and the field mask keeps software from
  // setting any bit that has no function behind it.
  wire [31:0] lane_mask;

  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : g_lane
      assign lane_mask[8*b +: 8] = {8{pstrb[b]}};
    end
  endgenerate

  wire [31:0] wr_mask     = lane_mask & iopgm_pkg::CONFIG_WMASK;
  wire [31:0] keep_bits   = io_pin_group_config & ~wr_mask;
  wire [31:0] new_bits    = pwdata & wr_mask;
  wire [31:0] next_config = keep_bits | new_bits;

  // Status word: how many pins have either override set. The count is
  // combinational and only reaches the bus through the read register, so
  // a read sees the overrides as they stood in its setup cycle.
  wire [NPINS-1:0] pin_overridden;

  genvar k;
  generate
    for (k = 0; k < NPINS; k++) begin : g_ovr
      assign pin_overridden[k] = basic_gpio_override[k] |
                                 advanced_gpio_override[k];
    end
  endgenerate

  // Seven bits hold any count up to 127, which covers every pin.
  function automatic logic [6:0] count_set(
    input logic [NPINS-1:0] flags
  );
    logic [6:0] total;
    total = 7'h00;
    for (int i = 0; i < NPINS; i++) begin
      total = total + 7'(flags[i]);
    end
    return total;
  endfunction : count_set

  wire [6:0]  ovr_count   = count_set(pin_overridden);
  wire [31:0] status_word = {25'h0000000, ovr_count};

  // Read mux. An unmapped address returns zero alongside the error flag.
  wire [31:0] next_rdata = sel_config ? io_pin_group_config :
                           sel_status ? status_word         :
                                        32'h0000_0000;

  // Single-cycle access phase: the slave never inserts wait states.
  // A write to the read-only status word is dropped without an error, as
  // the address itself is mapped.
  assign pready  = 1'b1;
  assign pslverr = access_phase && !mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_pin_group_config <= iopgm_pkg::CONFIG_RESET;
    end else if (wr_config) begin
      io_pin_group_config <= next_config;
    end
  end

  // Read data is captured in the setup cycle, so it is already stable
  // when the access phase is sampled, and it holds until the next read.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= next_rdata;
    end
  end

  wire [2:0] upper_raw  = io_pin_group_config[iopgm_pkg::UPPER_SEL_MSB:
                                              iopgm_pkg::UPPER_SEL_LSB];
  wire       lower_raw  = io_pin_group_config[iopgm_pkg::LOWER_SEL_BIT];
  wire       acc_sel    = io_pin_group_config[iopgm_pkg::ACC_UART_BIT];
  wire       upper_rsvd = (upper_raw > 3'h5);

  // Values 6 and 7 collapse to plain GPIO so no stray peripheral connects.
  assign route.upper_mode = upper_rsvd ? iopgm_pkg::UPPER_GPIO :
    iopgm_pkg::iopgm_upper_type'(upper_raw);
  assign route.lower_pif       = lower_raw;
  assign route.acc_uart_on_pif = acc_sel;
  // The peripheral UART is busy with the accessory when select is 0, so
  // the upper group may only use it while select is 1.
  assign route.lpp_uart_free   = acc_sel;

  // The USB PHY is not touched here; software must enable it itself.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_uart_on_pif_ctrl <= 1'b0;
    end else begin
      acc_uart_on_pif_ctrl <= route.acc_uart_on_pif;
    end
  end

  // Out of reset select is 0, so the peripheral UART serves the accessory.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_perf_uart_for_acc <= 1'b1;
    end else begin
      low_perf_uart_for_acc <= !route.lpp_uart_free;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lower_group_pif <= 1'b0;
    end else begin
      lower_group_pif <= route.lower_pif;
    end
  end

  // Upper group pin map, by position within the group: the first four pins
  // carry the UART while it is free, the next four SPI (parallel data in
  // mode 5) and the last four I2S. Pins outside both groups only ever see
  // the overrides. Every pin has its own output register, so a write to the
  // configuration reaches all pads on the same edge, one edge after the
  // write itself.
  genvar g;
  generate
    for (g = 0; g < NPINS; g++) begin : g_pin
      iopgm_pin_decode #(.PIN(g)) u_dec (
        .pclk              (pclk),
        .presetn           (presetn),
        .route             (route),
        .basic_override    (basic_gpio_override[g]),
        .advanced_override (advanced_gpio_override[g]),
        .func              (pin_func[g])
      );
    end
  endgenerate

endmodule : iopgm_top
`default_nettype wire

//--- tb/iopgm_chk.sv
// Assertion checker bound to the pin-group multiplexer top.
`timescale 1ns/100ps
`default_nettype none
module iopgm_chk #(parameter int NPINS = 61) (
  input wire logic                      pclk,
  input wire logic                      presetn,
  input wire logic                      psel,
  input wire logic                      penable,
  input wire logic                      pwrite,
  input wire logic [31:0]               paddr,
  input wire logic [31:0]               pwdata,
  input wire logic [3:0]                pstrb,
  input wire logic                      pready,
  input wire logic                      pslverr,
  input wire logic [NPINS-1:0]          basic_gpio_override,
  input wire logic [NPINS-1:0]          advanced_gpio_override,
  input wire iopgm_pkg::iopgm_func_type pin_func [NPINS],
  input wire logic                      acc_uart_on_pif_ctrl,
  input wire logic                      low_perf_uart_for_acc,
  input wire logic                      lower_group_pif
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire cfg_wr = psel && penable && pwrite && paddr == iopgm_pkg::CONFIG_ADDR;
  chk_lower_write :
    assert property (cfg_wr && pstrb[0] |=> ##1
      lower_group_pif == $past(pwdata[4], 2)) else $error("lower select lost");
  chk_acc_write :
    assert property (cfg_wr && pstrb[0] |=> ##1
      acc_uart_on_pif_ctrl == $past(pwdata[1], 2))
      else $error("acc select lost");
  chk_acc_pair :
    assert property (acc_uart_on_pif_ctrl != low_perf_uart_for_acc)
      else $error("uart source flags disagree");
  chk_uart_gated :
    assert property (low_perf_uart_for_acc |->
      pin_func[46] != iopgm_pkg::FN_UART)
      else $error("uart on upper group while withheld");
  chk_lower_pif :
    assert property (!basic_gpio_override[33] && !advanced_gpio_override[33]
      ##1 lower_group_pif |-> pin_func[33] == iopgm_pkg::FN_PIF)
      else $error("pin 33 not on parallel data");
  chk_simple_ovr :
    assert property (basic_gpio_override[46] && !advanced_gpio_override[46]
      |=> pin_func[46] == iopgm_pkg::FN_SIMPLE)
      else $error("simple override lost");
  chk_complex_wins :
    assert property (advanced_gpio_override[47]
      |=> pin_func[47] == iopgm_pkg::FN_COMPLEX)
      else $error("complex not first");
  chk_unmapped_err :
    assert property (psel && penable && paddr != iopgm_pkg::CONFIG_ADDR &&
      paddr != iopgm_pkg::OVR_STATUS_ADDR |-> pslverr && pready)
      else $error("unmapped access not refused");
  cover property (cfg_wr);
  cover property (pslverr);
  cover property (pin_func[47] == iopgm_pkg::FN_COMPLEX);
endmodule : iopgm_chk
bind iopgm_top iopgm_chk #(.NPINS(NPINS)) chk_u (.*);
`default_nettype wire

//--- tb/tb_top.sv
// Self-checking testbench for the pin-group multiplexer.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin errors++; \
  $display("ERROR %s exp %0h got %0h", n, e, s); end end
module tb_top;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [31:0] paddr = 0, pwdata = 0, rdat, prdata, cfg;
  logic [3:0]  pstrb = 0;
  logic        pready, pslverr, rerr, acc, low_perf_peripheral, lpif;
  logic [60:0] bov = 0, aov = 0;
  iopgm_pkg::iopgm_func_type pf [61];
  int          errors = 0, compares = 0;
  iopgm_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .basic_gpio_override(bov), .advanced_gpio_override(aov), .pin_func(pf),
    .acc_uart_on_pif_ctrl(acc), .low_perf_uart_for_acc(low_perf_peripheral),
    .lower_group_pif(lpif));
  initial forever #4 pclk = ~pclk;
  task results;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results
  // A hung slave ends the run here instead of stalling the whole bench.
  task apb(input logic w, input logic [31:0] a, d, input logic [3:0] s);
    int n;
    n = 0;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rdat = prdata;
    rerr = pslverr;
    if (pready !== 1'b1) begin
      errors++;
      results();
    end
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask : apb
  function automatic logic [2:0] exp(int p, logic [2:0] m, logic a, logic l);
    if (p < 46) return l ? 3'h4 : 3'h0;
    if (p < 50) return (a && m inside {1, 4, 5}) ? 3'h1 : 3'h0;
    if (p < 54) return m inside {2, 4} ? 3'h2 : (m == 5 ? 3'h4 : 3'h0);
    return m inside {3, 4, 5} ? 3'h3 : 3'h0;
  endfunction : exp
  task check_modes;
    logic [2:0] ef;
    for (int i = 0; i < 16; i++) begin
      cfg = {21'h0, i[2:0], 3'h0, i[0] ^ i[3], 2'h0, i[3], 1'h0};
      apb(1, iopgm_pkg::CONFIG_ADDR, cfg | ~32'h712, 4'hf);
      apb(0, iopgm_pkg::CONFIG_ADDR, 32'h0, 4'h0);
      `CHK("config", cfg, rdat)
      @(negedge pclk);
      `CHK("acc", cfg[1], acc)
      `CHK("lpp", !cfg[1], low_perf_peripheral)
      `CHK("lpif", cfg[4], lpif)
      for (int p = 33; p < 58; p++) begin
        ef = exp(p, cfg[10:8], cfg[1], cfg[4]);
        `CHK("pin", ef, pf[p])
      end
      @(posedge pclk);
    end
  endtask : check_modes
  task check_override;
    apb(1, iopgm_pkg::CONFIG_ADDR, 32'h402, 4'hf);
    bov <= 61'h3 << 46;
    aov <= (61'h1 << 47) | 61'h8;
    apb(0, iopgm_pkg::OVR_STATUS_ADDR, 32'h0, 4'h0);
    `CHK("count", 32'h3, rdat)
    `CHK("simple", 3'h5, pf[46])
    `CHK("complex", 3'h6, pf[47])
    `CHK("outside", 3'h6, pf[3])
    `CHK("uart", 3'h1, pf[48])
  endtask : check_override
  task check_bus;
    apb(1, 32'he0051010, 32'hffff_ffff, 4'hf);
    `CHK("werr", 1'b1, rerr)
    apb(0, 32'he0051010, 32'h0, 4'h0);
    `CHK("rerr", 1'b1, rerr)
    `CHK("rzero", 32'h0, rdat)
    apb(1, iopgm_pkg::CONFIG_ADDR, 32'h510, 4'h2);
    apb(0, iopgm_pkg::CONFIG_ADDR, 32'h0, 4'h0);
    `CHK("strobe", 32'h502, rdat)
  endtask : check_bus
  // A reset in mid-run must bring every field and output back to idle.
  task check_reset;
    apb(1, iopgm_pkg::CONFIG_ADDR, 32'h0000_0512, 4'hf);
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    @(negedge pclk);
    `CHK("rst acc", 1'b0, acc)
    `CHK("rst lpp", 1'b1, low_perf_peripheral)
    `CHK("rst lpif", 1'b0, lpif)
    `CHK("rst pin", 3'h0, pf[50])
    @(posedge pclk);
    apb(0, iopgm_pkg::CONFIG_ADDR, 32'h0, 4'h0);
    `CHK("rst config", iopgm_pkg::CONFIG_RESET, rdat)
  endtask : check_reset
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    @(negedge pclk);
    `CHK("rst lpp", 1'b1, low_perf_peripheral)
    `CHK("rst pin", 3'h0, pf[50])
    @(posedge pclk);
    check_modes();
    check_override();
    check_bus();
    check_reset();
    results();
  end
endmodule : tb_top
`default_nettype wire
